// File: ocg_pkg.sv
package ocg_pkg;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [7:0] IDX_FAULT_FLAGS = 8'h06;
    localparam logic [7:0] IDX_PIN_LEVEL = 8'h07;
    localparam logic [7:0] IDX_PAIR_LEVEL = 8'h08;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h0A;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h0B;

    // ************************************************************
    // Reset values and field layout
    // ************************************************************
    localparam logic [15:0] RST_FAULT_FLAGS = 16'h000F;
    localparam logic [15:0] RST_PIN_LEVEL = 16'h0000;
    localparam logic [15:0] RST_PAIR_LEVEL = 16'h0000;
    localparam logic [3:0] RST_IRQ_STATUS = 4'h0;
    localparam logic [3:0] RST_IRQ_MASK = 4'h0;
    localparam int FAULT_FLAG_W = 4;
    localparam int BIT_A_HIGH = 3;
    localparam int BIT_A_LOW = 2;
    localparam int BIT_B_HIGH = 1;
    localparam int BIT_B_LOW = 0;
    localparam int PIN_COUNT = 5;
    localparam int PAIR_COUNT = 4;
    localparam int LEVEL_CODE_W = 2;
    localparam int PAIR_HI_POS = 8;

    // ************************************************************
    // Level codes
    // ************************************************************
    localparam logic [1:0] CODE_LOW = 2'b00;
    localparam logic [1:0] CODE_WEAK_LOW = 2'b01;
    localparam logic [1:0] CODE_WEAK_HIGH = 2'b10;
    localparam logic [1:0] CODE_HIGH = 2'b11;
    localparam int STRONG_PERMILLE = 666;
    localparam int PERMILLE = 1000;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int LEVEL_WINDOW_US = 100;
    localparam int LEVEL_WINDOW_CYCLES = (LEVEL_WINDOW_US * 1000) / CLK_PERIOD_NS;

endpackage : ocg_pkg

// File: ocg_level_meter.sv
`timescale 1ns/10ps
module ocg_level_meter #(
    parameter int WINDOW_CYCLES = ocg_pkg::LEVEL_WINDOW_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic pin_i,
    output logic [1:0] level_code_o
);

    localparam int CW = $clog2(WINDOW_CYCLES + 1);
    localparam logic [CW-1:0] WIN_LAST = CW'(WINDOW_CYCLES - 1);

    logic [CW-1:0] win_cnt;
    logic [CW-1:0] high_cnt;
    logic [CW-1:0] next_high_total;

    // A share of exactly 66.6% counts as weak; only a larger share is called strong.
    function automatic logic [1:0] classify(input int high_cyc, input int total);
        int low_cyc;
        low_cyc = total - high_cyc;
        if (high_cyc * ocg_pkg::PERMILLE > ocg_pkg::STRONG_PERMILLE * total) begin
            classify = ocg_pkg::CODE_HIGH;
        end else if (2 * high_cyc > total) begin
            classify = ocg_pkg::CODE_WEAK_HIGH;
        end else if (low_cyc * ocg_pkg::PERMILLE > ocg_pkg::STRONG_PERMILLE * total) begin
            classify = ocg_pkg::CODE_LOW;
        end else begin
            classify = ocg_pkg::CODE_WEAK_LOW;
        end
    endfunction : classify

    assign next_high_total = high_cnt + CW'(pin_i);

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            win_cnt <= '0;
            high_cnt <= '0;
        end else if (win_cnt == WIN_LAST) begin
            win_cnt <= '0;
            high_cnt <= '0;
        end else begin
            win_cnt <= win_cnt + CW'(1);
            high_cnt <= next_high_total;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            level_code_o <= ocg_pkg::CODE_LOW;
        end else if (win_cnt == WIN_LAST) begin
            level_code_o <= classify(int'(next_high_total), WINDOW_CYCLES);
        end
    end

endmodule : ocg_level_meter

// File: ocg_regs.sv
// Our own choice: the APB register port.
`timescale 1ns/10ps
module ocg_regs #(
    parameter int DATA_W = 24,
    parameter int COUNT_W = 8,
    parameter int WINDOW_CYCLES = ocg_pkg::LEVEL_WINDOW_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic irq_o,
    input wire logic signed [DATA_W-1:0] conv_a_data_i,
    input wire logic conv_a_valid_i,
    input wire logic signed [DATA_W-1:0] conv_b_data_i,
    input wire logic conv_b_valid_i,
    input wire logic signed [DATA_W-1:0] conv_a_high_thresh_i,
    input wire logic signed [DATA_W-1:0] conv_a_low_thresh_i,
    input wire logic signed [DATA_W-1:0] conv_b_high_thresh_i,
    input wire logic signed [DATA_W-1:0] conv_b_low_thresh_i,
    input wire logic [COUNT_W-1:0] conv_a_count_i,
    input wire logic [COUNT_W-1:0] conv_b_count_i,
    input wire logic [ocg_pkg::PIN_COUNT-1:0] pin_i,
    input wire logic [ocg_pkg::PAIR_COUNT-1:0] pair_pin_i
);

    localparam int NLEV = ocg_pkg::PIN_COUNT + ocg_pkg::PAIR_COUNT;
    localparam int NF = ocg_pkg::FAULT_FLAG_W;

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic logic hits(input logic [11:0] addr, input logic [7:0] idx);
        hits = (addr[1:0] == 2'b00) && (addr[11:2] == {2'b00, idx});
    endfunction : hits

    logic bus_done;
    logic wr_done;
    logic lo_lanes;
    logic [15:0] wdata16;
    logic hit_fault;
    logic hit_pin;
    logic hit_pair;
    logic hit_stat;
    logic hit_mask;
    logic hit_any;

    // Registers are 16 bits wide, so only byte lanes 0 and 1 reach them.
    assign bus_done = psel_i && penable_i && pready_o;
    assign wr_done = bus_done && pwrite_i;
    assign lo_lanes = pstrb_i[0] && pstrb_i[1];
    assign wdata16 = lo_lanes ? pwdata_i[15:0] : 16'h0000;
    assign hit_fault = hits(paddr_i, ocg_pkg::IDX_FAULT_FLAGS);
    assign hit_pin = hits(paddr_i, ocg_pkg::IDX_PIN_LEVEL);
    assign hit_pair = hits(paddr_i, ocg_pkg::IDX_PAIR_LEVEL);
    assign hit_stat = hits(paddr_i, ocg_pkg::IDX_IRQ_STATUS);
    assign hit_mask = hits(paddr_i, ocg_pkg::IDX_IRQ_MASK);
    assign hit_any = hit_fault || hit_pin || hit_pair || hit_stat || hit_mask;

    // ************************************************************
    // Overcurrent comparators
    // ************************************************************
    // A net, because each comparator slice drives its own bit.
    wire logic [NF-1:0] fault_evt;

    // The counter saturates, so a fault that persists keeps re-asserting and
    // re-arms the flag straight after the host clears it.
    for (genvar k = 0; k < NF; k++) begin : g_cmp
        localparam bit IS_A = (k == ocg_pkg::BIT_A_HIGH) || (k == ocg_pkg::BIT_A_LOW);
        localparam bit IS_HIGH = (k == ocg_pkg::BIT_A_HIGH) || (k == ocg_pkg::BIT_B_HIGH);
        logic signed [DATA_W-1:0] sample;
        logic signed [DATA_W-1:0] thresh;
        logic valid;
        logic beyond;
        logic [COUNT_W-1:0] need;
        logic [COUNT_W-1:0] run;
        logic evt;
        assign sample = IS_A ? conv_a_data_i : conv_b_data_i;
        assign valid = IS_A ? conv_a_valid_i : conv_b_valid_i;
        assign need = IS_A ? conv_a_count_i : conv_b_count_i;
        if (IS_HIGH) begin : g_hi
            assign thresh = IS_A ? conv_a_high_thresh_i : conv_b_high_thresh_i;
            assign beyond = sample > thresh;
        end else begin : g_lo
            assign thresh = IS_A ? conv_a_low_thresh_i : conv_b_low_thresh_i;
            assign beyond = sample < thresh;
        end
        always_ff @(posedge clk_sys_i) begin
            if (sys_rst_i) begin
                run <= '0;
            end else if (valid) begin
                if (!beyond) begin
                    run <= '0;
                end else if (run != '1) begin
                    run <= run + COUNT_W'(1);
                end
            end
        end
        // A count of zero behaves as one conversion.
        always_ff @(posedge clk_sys_i) begin
            if (sys_rst_i) begin
                evt <= 1'b0;
            end else begin
                evt <= valid && beyond && ((run + COUNT_W'(1)) >= need || run == '1);
            end
        end
        assign fault_evt[k] = evt;
    end

    // ************************************************************
    // Fault flags, active low
    // ************************************************************
    logic [NF-1:0] fault_flags_n;
    logic [NF-1:0] flag_clr;

    assign flag_clr = (wr_done && hit_fault) ? wdata16[NF-1:0] : '0;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            fault_flags_n <= ocg_pkg::RST_FAULT_FLAGS[NF-1:0];
        end else begin
            fault_flags_n <= ~fault_evt & (fault_flags_n | flag_clr);
        end
    end

    // ************************************************************
    // Interrupt status and mask
    // ************************************************************
    logic [NF-1:0] irq_status;
    logic [NF-1:0] irq_mask;
    logic [NF-1:0] stat_clr;

    assign stat_clr = (wr_done && hit_stat) ? wdata16[NF-1:0] : '0;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            irq_status <= ocg_pkg::RST_IRQ_STATUS;
        end else begin
            irq_status <= fault_evt | (irq_status & ~stat_clr);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            irq_mask <= ocg_pkg::RST_IRQ_MASK;
        end else if (wr_done && hit_mask && lo_lanes) begin
            irq_mask <= pwdata_i[NF-1:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status & irq_mask);
        end
    end

    // ************************************************************
    // Pin level readback
    // ************************************************************
    logic [NLEV-1:0] lev_pins;
    wire logic [2*NLEV-1:0] lev_codes;
    logic [15:0] pin_level_readback;
    logic [15:0] pair_pin_level_readback;

    assign lev_pins = {pair_pin_i, pin_i};

    for (genvar p = 0; p < NLEV; p++) begin : g_lev
        ocg_level_meter #(
            .WINDOW_CYCLES(WINDOW_CYCLES)
        ) u_meter (
            .clk_sys_i(clk_sys_i),
            .sys_rst_i(sys_rst_i),
            .pin_i(lev_pins[p]),
            .level_code_o(lev_codes[2*p +: 2])
        );
    end

    // Pair pins: 0B at 1:0, 1B at 3:2, 0A at 9:8, 1A at 11:10.
    assign pin_level_readback = {6'b00_0000, lev_codes[9:0]};
    assign pair_pin_level_readback = {4'h0, lev_codes[17:14], 4'h0, lev_codes[13:10]};

    // ************************************************************
    // APB answer
    // ************************************************************
    logic [15:0] rd_mux;

    always_comb begin
        rd_mux = 16'h0000;
        if (hit_fault) begin
            rd_mux = {12'h000, fault_flags_n};
        end else if (hit_pin) begin
            rd_mux = pin_level_readback;
        end else if (hit_pair) begin
            rd_mux = pair_pin_level_readback;
        end else if (hit_stat) begin
            rd_mux = {12'h000, irq_status};
        end else if (hit_mask) begin
            rd_mux = {12'h000, irq_mask};
        end
    end

    // One wait state: pready rises in the second access cycle, which gives the
    // read mux a full cycle and keeps every bus output registered.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && penable_i && !pready_o) begin
            pready_o <= 1'b1;
            pslverr_o <= !hit_any;
            prdata_o <= pwrite_i ? 32'h0000_0000 : {16'h0000, rd_mux};
        end else begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end
    end

endmodule : ocg_regs

// File: ocg_regs_properties.sv
`timescale 1ns/10ps
module ocg_regs_chk (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);
    property p_rst_quiet;
        $fell(sys_rst_i) |-> !pready_o && !irq_o && prdata_o == 32'h0000_0000;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
    property p_flag_rsvd;
        pready_o && !pwrite_i && paddr_i == 12'h018 |-> prdata_o[31:4] == 28'h000_0000;
    endproperty
    a_flag_rsvd: assert property (p_flag_rsvd) else $error("flag upper bits set");
    property p_pin_rsvd;
        pready_o && !pwrite_i && paddr_i == 12'h01C |-> prdata_o[31:10] == 22'h00_0000;
    endproperty
    a_pin_rsvd: assert property (p_pin_rsvd) else $error("pin upper bits set");
    property p_pair_map;
        pready_o && paddr_i == 12'h020 |-> !pslverr_o;
    endproperty
    a_pair_map: assert property (p_pair_map) else $error("pair register not mapped");
    property p_unmapped;
        pready_o && paddr_i == 12'h100 |-> pslverr_o && prdata_o == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
    property p_rdy_lat;
        psel_i && penable_i && !pready_o |=> pready_o;
    endproperty
    a_rdy_lat: assert property (p_rdy_lat) else $error("answer late");
    property p_rdy_pulse;
        pready_o |=> !pready_o ##1 !pready_o;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready not a pulse");
    property p_idle_data;
        !pready_o |-> prdata_o == 32'h0000_0000 && !pslverr_o;
    endproperty
    a_idle_data: assert property (p_idle_data) else $error("read data outside answer");
    c_err: cover property (pready_o && pslverr_o);
    c_irq: cover property ($rose(irq_o));
    c_wr_flags: cover property (pready_o && pwrite_i && paddr_i == 12'h018);
endmodule : ocg_regs_chk
bind ocg_regs ocg_regs_chk chk_u (.clk_sys_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .prdata_o, .pready_o, .pslverr_o, .irq_o);

// File: ocg_apb_host.sv
`timescale 1ns/10ps
module ocg_apb_host (
    input wire logic clk_sys_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [11:0] paddr_o,
    output logic [31:0] pwdata_o,
    output logic [3:0] pstrb_o,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h000;
        pwdata_o = 32'h0000_0000;
        pstrb_o = 4'hF;
    end
    // Starting on a fresh edge keeps back-to-back calls from assigning psel twice in one step.
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge clk_sys_i);
        psel_o <= 1'b1;
        pwrite_o <= wr;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_sys_i);
        penable_o <= 1'b1;
        @(posedge clk_sys_i);
        while (pready_i !== 1'b1) @(posedge clk_sys_i);
        q = prdata_i;
        err = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        pwdata_o <= ~d;
    endtask : xfer
endmodule : ocg_apb_host

// File: overcurrent_gpio_status_regs_tb.sv
`timescale 1ns/10ps
module overcurrent_gpio_status_regs_tb;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] pstrb;
    logic [3:0] m;
    logic signed [23:0] cdat = 24'h00_0000;
    logic a_vld = 1'b0;
    logic b_vld = 1'b0;
    logic [7:0] cnt = 8'h00;
    logic [4:0] pins = 5'h00;
    logic [3:0] pairs = 4'h0;
    logic pwm_on = 1'b0;
    int phase = 0;
    int error_cnt = 0;
    int checks = 0;
    always #25 clk_sys_i = ~clk_sys_i;
    ocg_regs #(.WINDOW_CYCLES(30)) dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq), .conv_a_data_i(cdat),
        .conv_a_valid_i(a_vld), .conv_b_data_i(cdat), .conv_b_valid_i(b_vld),
        .conv_a_high_thresh_i(24'h00_0064), .conv_a_low_thresh_i(24'hFF_FF9C),
        .conv_b_high_thresh_i(24'h00_0064), .conv_b_low_thresh_i(24'hFF_FF9C),
        .conv_a_count_i(cnt), .conv_b_count_i(cnt), .pin_i(pins), .pair_pin_i(pairs));
    ocg_apb_host host_u (.clk_sys_i(clk_sys_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb), .prdata_i(prdata), .pready_i(pready),
        .pslverr_i(pslverr));
    // The pattern period equals the window, so every window sees the same duty whatever its phase.
    always @(posedge clk_sys_i) begin
        if (pwm_on) begin
            phase <= (phase + 1) % 30;
            pins <= {phase < 21, 1'b0, phase < 15, phase < 19, 1'b1};
            pairs <= 4'b1001;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        host_u.xfer(1'b0, a, 32'h0000_0000, rdat, err);
        check(rdat, exp);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, rdat, err);
    endtask : wr
    task automatic give_verdict;
        $display("Mismatches %0d, comparisons %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (8) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        rd(12'h018, 32'h0000_000F);
        rd(12'h01C, 32'h0000_0000);
        rd(12'h020, 32'h0000_0000);
        wr(12'h018, 32'hFFFF_FFF0);
        rd(12'h018, 32'h0000_000F);
        rd(12'h100, 32'h0000_0000);
        check({31'h0000_0000, err}, 32'h0000_0001);
        // Bit i: odd means above the high limit, the two low bits belong to converter B.
        for (int i = 0; i < 4; i++) begin
            if (i == 1) wr(12'h02C, 32'h0000_000F);
            m = 4'b0001 << i;
            cnt <= 8'(i);
            cdat <= i[0] ? 24'h00_00C8 : 24'hFF_FF38;
            a_vld <= i > 1;
            b_vld <= i < 2;
            repeat (3) @(posedge clk_sys_i);
            a_vld <= 1'b0;
            b_vld <= 1'b0;
            repeat (4) @(posedge clk_sys_i);
            rd(12'h018, {28'h000_0000, ~m});
            check({31'h0000_0000, irq}, {31'h0000_0000, i != 0});
            rd(12'h028, {28'h000_0000, m});
            wr(12'h018, 32'h0000_0000);
            rd(12'h018, {28'h000_0000, ~m});
            wr(12'h018, {28'h000_0000, m});
            wr(12'h028, {28'h000_0000, m});
            rd(12'h018, 32'h0000_000F);
            check({31'h0000_0000, irq}, 32'h0000_0000);
        end
        // A fault seen on every conversion keeps re-arming, so it beats the clearing write.
        cnt <= 8'h00;
        cdat <= 24'hFF_FF38;
        b_vld <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        wr(12'h018, 32'h0000_0001);
        rd(12'h018, 32'h0000_000E);
        check({31'h0000_0000, irq}, 32'h0000_0001);
        rd(12'h02C, 32'h0000_000F);
        b_vld <= 1'b0;
        rd(12'h01A, 32'h0000_0000);
        check({31'h0000_0000, err}, 32'h0000_0001);
        // A second reset in mid-run must bring back the reset values.
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        rd(12'h018, 32'h0000_000F);
        rd(12'h028, 32'h0000_0000);
        rd(12'h02C, 32'h0000_0000);
        check({31'h0000_0000, irq}, 32'h0000_0000);
        pwm_on <= 1'b1;
        repeat (75) @(posedge clk_sys_i);
        rd(12'h01C, 32'h0000_031B);
        rd(12'h020, 32'h0000_0C03);
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        error_cnt++;
        give_verdict();
    end
endmodule : overcurrent_gpio_status_regs_tb
